// file: shared/modem_cfg_map.vh
// Register offsets, field positions and reset values of the modem config bank
`ifndef MODEM_CFG_MAP_VH
`define MODEM_CFG_MAP_VH
`define ADDR_MODEM_CONFIG 8'h00
`define ADDR_PORT_SELECT 8'h01
`define ADDR_SCAN_CONTROL 8'h02
`define ADDR_RX_TX_LEVELS 8'h03
`define ADDR_DWELL_HIGH_MASK 8'h04
`define ADDR_DWELL_LOW 8'h05
`define ADDR_SCAN_RESULT 8'h06
`define ADDR_LIVE_STATUS 8'h07
`define ADDR_PART_ID 8'h08
`define ADDR_REV_ID 8'h09
`define CFG_KEEPALIVE_BIT 7
`define CFG_POWER_DOWN_BIT 6
`define CFG_STANDBY_BIT 5
`define CFG_CARRIER_FORCE_BIT 4
`define CFG_DRIVE_HI 3
`define CFG_DRIVE_LO 2
`define CFG_RATE_HI 1
`define CFG_RATE_LO 0
`define SEL_DISCONNECT_BIT 2
`define SEL_PORT_HI 1
`define SEL_PORT_LO 0
`define CFG_WRITE_MASK 8'hff
`define SEL_WRITE_MASK 8'h07
`define MODEM_CONFIG_RESET 8'h84
`define PORT_SELECT_RESET 8'h00
`define CLK_HZ 50000000
`define RATE_9K6_BPS 9600
`define RATE_38K4_BPS 38400
`define RATE_115K2_BPS 115200
`define DIV_9K6 (`CLK_HZ / `RATE_9K6_BPS)
`define DIV_38K4 (`CLK_HZ / `RATE_38K4_BPS)
`define DIV_115K2 (`CLK_HZ / `RATE_115K2_BPS)
`endif

// file: rtl/modem_config_mux_regs.v
// Configuration and port-select register bank of a four-port OOK modem
`timescale 1ns/1ns
`default_nettype none
`include "modem_cfg_map.vh"
module modem_config_mux_regs #(
    parameter DIV_W = 16
) (
    input wire i_clk,              // 50 MHz system clock
    input wire i_rstn,             // Synchronous reset, active low
    input wire i_wr_en,            // Register write strobe, one cycle
    input wire i_rd_en,            // Register read strobe, one cycle
    input wire [7:0] i_addr,       // Register address
    input wire [7:0] i_wdata,      // Write data
    input wire i_tx_key_input_n,   // Keying pin, low keys carrier, async
    output reg [7:0] o_rdata,      // Read data, valid cycle after strobe
    output reg o_rvalid,           // Read data valid pulse
    output reg o_crystal_run,      // Crystal oscillator enable
    output reg o_pll_on,           // Synthesizer PLL enable
    output reg o_rx_on,            // Receiver enable
    output reg o_tx_on,            // Transmitter enable
    output reg o_tx_carrier,       // Internal carrier gate
    output reg o_transmit_busy_flag, // Transmit active status
    output reg [1:0] o_clock_out_drive, // Clock-out drive level, 0 off
    output reg o_crystal_clock_out_en, // Clock-out buffer enable
    output reg o_bit_tick,         // Bit-rate enable pulse
    output reg [1:0] o_antenna_port_select, // Selected RF port
    output reg o_port_connect      // Modem routed to common port
);

// ==========================================
// Registers
reg [7:0] modem_config_ff;
reg [7:0] port_select_ff;
reg [2:0] key_sync_ff;
reg key_level_ff;
reg [DIV_W-1:0] div_cnt_ff;
reg [DIV_W-1:0] div_limit;
wire pdown = modem_config_ff[`CFG_POWER_DOWN_BIT];
wire stby = modem_config_ff[`CFG_STANDBY_BIT];
wire force_on = modem_config_ff[`CFG_CARRIER_FORCE_BIT];
wire [1:0] drive = modem_config_ff[`CFG_DRIVE_HI:`CFG_DRIVE_LO];
wire [1:0] rate = modem_config_ff[`CFG_RATE_HI:`CFG_RATE_LO];
wire keyed = ~key_level_ff | force_on;
wire keepalive = modem_config_ff[`CFG_KEEPALIVE_BIT];
wire xtal_on = ~pdown | keepalive;

always @(posedge i_clk) begin
    if (!i_rstn) begin
        modem_config_ff <= `MODEM_CONFIG_RESET;
        port_select_ff <= `PORT_SELECT_RESET;
    end else if (i_wr_en) begin
        if (i_addr == `ADDR_MODEM_CONFIG) begin
            modem_config_ff <= i_wdata & `CFG_WRITE_MASK;
        end
        if (i_addr == `ADDR_PORT_SELECT) begin
            port_select_ff <= i_wdata & `SEL_WRITE_MASK;
        end
    end
end

// ==========================================
// Read port
always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_rdata <= 8'h00;
        o_rvalid <= 1'b0;
    end else begin
        o_rvalid <= i_rd_en;
        if (i_rd_en) begin
            case (i_addr)
                `ADDR_MODEM_CONFIG: o_rdata <= modem_config_ff;
                `ADDR_PORT_SELECT: o_rdata <= port_select_ff;
                `ADDR_LIVE_STATUS: o_rdata <= {5'h00, keyed, 2'b00};
                default: o_rdata <= 8'h00;
            endcase
        end
    end
end

// ==========================================
// Keying input synchroniser
always @(posedge i_clk) begin
    if (!i_rstn) begin
        key_sync_ff <= 3'b111;
        key_level_ff <= 1'b1;
    end else begin
        key_sync_ff <= {key_sync_ff[1:0], i_tx_key_input_n};
        if (key_sync_ff[2] == key_sync_ff[1]) begin
            key_level_ff <= key_sync_ff[2];
        end
    end
end

// ==========================================
// Bit-rate divider
// Clocks per bit, cut to the counter width on purpose
localparam integer LIM_9K6 = `DIV_9K6;
localparam integer LIM_38K4 = `DIV_38K4;
localparam integer LIM_115K2 = `DIV_115K2;

always @* begin
    case (rate)
        2'b00: div_limit = LIM_9K6[DIV_W-1:0];
        2'b01: div_limit = LIM_38K4[DIV_W-1:0];
        2'b10: div_limit = LIM_115K2[DIV_W-1:0];
        default: div_limit = LIM_9K6[DIV_W-1:0];
    endcase
end

always @(posedge i_clk) begin
    if (!i_rstn) begin
        div_cnt_ff <= {DIV_W{1'b0}};
        o_bit_tick <= 1'b0;
    end else if (div_cnt_ff >= div_limit - 1'b1) begin
        div_cnt_ff <= {DIV_W{1'b0}};
        o_bit_tick <= 1'b1;
    end else begin
        div_cnt_ff <= div_cnt_ff + 1'b1;
        o_bit_tick <= 1'b0;
    end
end

// ==========================================
// Power controls
always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_crystal_run <= 1'b1;
    end else begin
        o_crystal_run <= xtal_on;
    end
end

always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_pll_on <= 1'b1;
    end else begin
        o_pll_on <= ~pdown;
    end
end

always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_rx_on <= 1'b1;
    end else begin
        o_rx_on <= ~pdown;
    end
end

// Standby only drops the transmitter
always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_tx_on <= 1'b1;
    end else begin
        o_tx_on <= ~pdown & ~stby;
    end
end

// ==========================================
// Carrier and transmit status
always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_tx_carrier <= 1'b0;
    end else begin
        o_tx_carrier <= keyed;
    end
end

always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_transmit_busy_flag <= 1'b0;
    end else begin
        o_transmit_busy_flag <= keyed;
    end
end

// ==========================================
// Clock output
always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_clock_out_drive <= 2'b01;
    end else begin
        o_clock_out_drive <= drive;
    end
end

// No clock out while the crystal is stopped
always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_crystal_clock_out_en <= 1'b1;
    end else begin
        o_crystal_clock_out_en <= (drive != 2'b00) & xtal_on;
    end
end

// ==========================================
// Port routing
always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_antenna_port_select <= 2'b00;
    end else begin
        o_antenna_port_select <=
            port_select_ff[`SEL_PORT_HI:`SEL_PORT_LO];
    end
end

always @(posedge i_clk) begin
    if (!i_rstn) begin
        o_port_connect <= 1'b1;
    end else begin
        o_port_connect <= ~port_select_ff[`SEL_DISCONNECT_BIT];
    end
end

endmodule
`default_nettype wire

// file: bench/modem_regs_chk.sv
// Port assertions for the modem config bank
`timescale 1ns/1ns
`default_nettype none
module modem_regs_chk (
    input wire logic i_clk, // Clock
    input wire logic i_rstn, // Reset, active low
    input wire logic i_wr_en, // Write strobe
    input wire logic i_rd_en, // Read strobe
    input wire logic o_rvalid, // Read valid
    input wire logic [7:0] i_addr, // Address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic [7:0] o_rdata, // Read data
    input wire logic o_crystal_run, // Crystal enable
    input wire logic o_pll_on, // PLL enable
    input wire logic o_rx_on, // Receiver enable
    input wire logic o_tx_on, // Transmitter enable
    input wire logic o_tx_carrier, // Carrier gate
    input wire logic o_port_connect, // Routed to common port
    input wire logic [1:0] o_clock_out_drive, // Clock-out drive
    input wire logic [1:0] o_antenna_port_select // Selected port
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_cfg; i_wr_en && i_addr == 8'h00; endsequence
    sequence s_sel; i_wr_en && i_addr == 8'h01; endsequence
    AST_SEL_RD: assert property (i_rd_en && i_addr == 8'h01 |=>
        o_rvalid && o_rdata[7:3] == 5'h00) else $error("select read");
    AST_PD: assert property (s_cfg |-> ##2
        o_pll_on == !$past(i_wdata[6], 2) && o_rx_on == o_pll_on)
        else $error("power down");
    AST_SBY: assert property (s_cfg |-> ##2
        o_tx_on == !($past(i_wdata[6], 2) || $past(i_wdata[5], 2)))
        else $error("standby");
    AST_XTAL: assert property (s_cfg |-> ##2
        o_crystal_run == ($past(i_wdata[7], 2) || !$past(i_wdata[6], 2)))
        else $error("crystal");
    AST_DRV: assert property (s_cfg |-> ##2
        o_clock_out_drive == $past(i_wdata[3:2], 2)) else $error("drive");
    AST_FORCE: assert property (s_cfg and i_wdata[4] |-> ##2
        o_tx_carrier) else $error("force");
    AST_PORT: assert property (s_sel |-> ##2
        o_antenna_port_select == $past(i_wdata[1:0], 2)) else $error("port");
    AST_OPEN: assert property (s_sel |-> ##2
        o_port_connect != $past(i_wdata[2], 2)) else $error("open");
endmodule
bind modem_config_mux_regs modem_regs_chk i_chk (.*);
`default_nettype wire

// file: bench/host_model.sv
// Register host driving the strobe access port
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic i_clk, // Clock
    input wire logic [7:0] i_rdata, // Read data
    input wire logic i_rvalid, // Read data valid
    output logic o_wr, // Write strobe
    output logic o_rd, // Read strobe
    output logic [7:0] o_addr, // Address
    output logic [7:0] o_wdata // Write data
);
    initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0_0000;
    // Released lines show inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk) {o_wr, o_addr, o_wdata} = {1'b1, a, d};
        @(negedge i_clk) {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
        repeat (2) @(negedge i_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk) {o_rd, o_addr} = {1'b1, a};
        @(negedge i_clk) {o_rd, o_addr} = {1'b0, ~a};
        @(posedge i_clk);
        d = i_rvalid ? i_rdata : 8'hxx;
    endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the modem config bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_tx_key_input_n = 1'b1;
    logic i_wr_en, i_rd_en, o_rvalid, o_crystal_run, o_pll_on, o_rx_on;
    logic o_tx_on, o_tx_carrier, o_transmit_busy_flag, o_bit_tick;
    logic o_crystal_clock_out_en, o_port_connect;
    logic [7:0] i_addr, i_wdata, o_rdata, d;
    logic [1:0] o_clock_out_drive, o_antenna_port_select;
    logic [7:0] cv [4] = '{8'h40, 8'hc0, 8'h28, 8'h0f};
    logic [7:0] ex [4] = '{8'h00, 8'h80, 8'hea, 8'hfe};
    int pr [3] = '{5208, 1302, 434};
    int failures = 0, compares = 0, n;
    initial forever #10 i_clk = ~i_clk;
    host_model i_host (.i_clk(i_clk), .i_rdata(o_rdata),
        .i_rvalid(o_rvalid), .o_wr(i_wr_en),
        .o_rd(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));
    modem_config_mux_regs i_dut (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic finish_test();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #1_000_000;
        failures++;
        finish_test();
    end
    initial begin
        repeat (6) @(negedge i_clk);
        i_rstn = 1'b1;
        rchk(8'h00, 8'h84);
        rchk(8'h01, 8'h00);
        for (int i = 0; i < 4; i++) begin
            i_host.wr(8'h00, cv[i]);
            chk({o_crystal_run, o_pll_on, o_rx_on, o_tx_on,
                o_clock_out_drive, o_crystal_clock_out_en, 1'b0},
                ex[i]);
            rchk(8'h00, cv[i]);
        end
        for (int r = 0; r < 3; r++) begin
            i_host.wr(8'h00, {6'h00, r[1:0]});
            repeat (2) @(posedge o_bit_tick);
            @(negedge i_clk);
            n = 0;
            do begin
                @(negedge i_clk);
                n++;
            end while (o_bit_tick !== 1'b1 && n < 6000);
            chk(n[15:0], pr[r][15:0]);
        end
        for (int p = 0; p < 4; p++) begin
            i_host.wr(8'h01, {5'h1f, p[0], p[1:0]});
            chk({o_antenna_port_select, o_port_connect}, {p[1:0], ~p[0]});
            rchk(8'h01, {5'h00, p[0], p[1:0]});
        end
        @(negedge i_clk);
        i_tx_key_input_n = 1'b0;
        repeat (8) @(negedge i_clk);
        chk({o_tx_carrier, o_transmit_busy_flag}, 2'b11);
        rchk(8'h07, 8'h04);
        @(negedge i_clk);
        i_tx_key_input_n = 1'b1;
        repeat (8) @(negedge i_clk);
        chk({o_tx_carrier, o_transmit_busy_flag}, 2'b00);
        i_host.wr(8'h00, 8'h14);
        chk({o_tx_carrier, o_transmit_busy_flag}, 2'b11);
        i_rstn = 1'b0;
        repeat (2) @(negedge i_clk);
        i_rstn = 1'b1;
        rchk(8'h00, 8'h84);
        rchk(8'h01, 8'h00);
        @(negedge i_clk);
        chk({o_tx_carrier, o_port_connect}, 2'b01);
        finish_test();
    end
endmodule
`default_nettype wire
